// File: bench/host_model.sv
// host-side partner: hard reset pin, serial soft reset request, pulled-up data line
// assumes the bench asks for actions just after the falling edge of the reference clock
`timescale 1ns/1ns
module host_model (
	input  wire logic i_clk,
	input  wire logic i_hard_req,
	input  wire logic i_soft_req,
	input  wire logic i_sda_oe_n,
	input  wire logic i_sda_val,
	output logic      o_hard_reset_n,
	output logic      o_soft_cmd,
	output logic      o_sda_level
);
	logic [7:0] since_reg = 8'h00;
	// pins are always driven to a defined level, never left floating
	assign o_hard_reset_n = !i_hard_req;
	// serial traffic is held back until 100 cycles after hard reset release
	assign o_soft_cmd = i_soft_req && (since_reg >= 8'h64);
	// open-drain line: released means pull-up level; a driven level wins, so a high drive shows
	assign o_sda_level = i_sda_oe_n ? 1'b1 : i_sda_val;
	always @(posedge i_clk)
	begin
		if (i_hard_req)
			since_reg <= 8'h00;
		else if (since_reg != 8'hFF)
			since_reg <= since_reg + 8'h01;
	end
endmodule : host_model

// File: bench/tb_top.sv
// self-checking bench for the reset and pin-state controller
// assumes the partner model drives the hard reset pin and soft reset pulses
`timescale 1ns/1ns
module tb_top;
	import rst_pin_pkg::*;
	logic         clk = 1'b0;
	logic         arst_n, hard_req, soft_req, standby, flash_in, sda_pull, booted, rel;
	logic         hard_n, soft_cmd, sda_lvl, core_n, ready, auto_cfg, pull_en, sda_rx, fl_rx;
	fw_mode_t     mode;
	flash_drive_t fdrive;
	pin_drive_t   pins;
	dev_state_t   state;
	int           n_errors = 0;
	int           check_count = 0;
	int           n;
	int           seed;
	// the reference clock never stops, even in reset
	always #25 clk = !clk;
	host_model host_model_i (.i_clk(clk), .i_hard_req(hard_req), .i_soft_req(soft_req),
		.i_sda_oe_n(pins.host_serial_data_oe_n), .i_sda_val(pins.host_serial_data),
		.o_hard_reset_n(hard_n),
		.o_soft_cmd(soft_cmd), .o_sda_level(sda_lvl));
	isp_reset_and_pin_states isp_reset_and_pin_states_i (.i_clk(clk), .i_arst_n(arst_n),
		.i_hard_reset_n(hard_n), .i_standby(standby), .i_host_serial_data(sda_lvl),
		.i_flash_data_in(flash_in), .i_soft_reset_cmd(soft_cmd), .i_sda_pull_low(sda_pull),
		.i_fw_booted(booted), .i_fw_mode(mode), .i_fw_sensor_release(rel),
		.i_flash_drive(fdrive), .o_pins(pins), .o_state(state), .o_core_reset_n(core_n),
		.o_host_link_ready(ready), .o_auto_config(auto_cfg), .o_flash_pullup_en(pull_en),
		.o_host_serial_data_rx(sda_rx), .o_flash_data_rx(fl_rx));
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1)
		begin
			n_errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask : cyc
	// bounded wait so a stuck state machine cannot hang the run
	task automatic wait_st(input dev_state_t s, output int k);
		k = 0;
		while (state !== s && k < 200)
		begin
			@(negedge clk);
			k++;
		end
	endtask : wait_st
	function automatic dev_state_t exp_fw(input fw_mode_t m);
		if (m === FW_SOFT_STANDBY)
			return ST_SOFT_STANDBY;
		return (m === FW_STREAMING) ? ST_STREAMING : ST_IDLE;
	endfunction : exp_fw
	// flash pins: engine levels only in streaming or idle, else clock 0, select 1, data 0
	function automatic logic [2:0] exp_flash(input fw_mode_t m, input flash_drive_t d);
		if (exp_fw(m) === ST_SOFT_STANDBY)
			return 3'h2;
		return d;
	endfunction : exp_flash
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	initial
	begin
		#(50 * 20000);
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report();
	end
	initial
	begin
		seed = 32'ha27a;
		{arst_n, hard_req, soft_req, standby, flash_in, sda_pull, booted, rel} = '0;
		// release asked for early so a low sensor reset can only come from the state
		rel = 1'b1;
		mode = FW_SOFT_STANDBY;
		fdrive = '0;
		cyc(5);
		arst_n = 1'b1;
		cyc(10);
		chk(state === ST_RESET && core_n === 1'b0, "por hold");
		wait_st(ST_DEFAULT, n);
		// default one edge after the stretch, counted from the tenth edge
		chk(n == int'(POR_STRETCH_CYCLES) + 1 - 10, "por exit");
		chk(auto_cfg === flash_in, "strap at por exit");
		chk(pins.sensor_reset_oe_n === 1'b0 && pins.sensor_reset_n === 1'b0, "sensor");
		$display("test por done");
		// pull low requested so the hi-Z check cannot pass by default
		sda_pull = 1'b1;
		hard_req = 1'b1;
		cyc(3);
		chk(state === ST_RESET && core_n === 1'b0, "hard enter");
		chk((pins.flash_clk_oe_n & pins.flash_cs_oe_n & pins.flash_dout_oe_n
			& pins.sensor_reset_oe_n & pins.host_serial_data_oe_n) === 1'b1, "hiz");
		cyc(50);
		chk(state === ST_RESET && ready === 1'b0, "hard hold");
		hard_req = 1'b0;
		// ready must not show within 100 cycles of the pin going high
		cyc(100);
		chk(ready === 1'b0 && state === ST_DEFAULT, "early ready");
		cyc(5);
		chk(ready === 1'b1, "late ready");
		$display("test hard reset done");
		// two soft resets back to back, the strap level flipped for each
		repeat (2)
		begin
			soft_req = 1'b1;
			flash_in = !flash_in;
			cyc(1);
			soft_req = 1'b0;
			chk(state === ST_RESET && core_n === 1'b0, "soft enter");
			chk(pins.sensor_reset_oe_n === 1'b0 && pins.sensor_reset_n === 1'b0, "srst");
			wait_st(ST_DEFAULT, n);
			chk(n == 9, "soft length");
			chk(auto_cfg === flash_in, "strap at soft exit");
		end
		$display("test soft reset done");
		booted = 1'b1;
		repeat (24)
		begin
			standby = 1'b1;
			cyc(4);
			chk(state === ST_HARD_STANDBY, "standby");
			mode = fw_mode_t'(2'($random(seed)));
			rel = 1'($random(seed));
			sda_pull = 1'($random(seed));
			flash_in = 1'($random(seed));
			fdrive = flash_drive_t'(3'($random(seed)));
			standby = 1'b0;
			cyc(4);
			chk(state === exp_fw(mode), "fw state");
			chk(pins.sensor_reset_n === rel && pins.sensor_reset_oe_n === 1'b0, "rel");
			chk(pins.host_serial_data === 1'b0
				&& pins.host_serial_data_oe_n === !sda_pull, "sda drive");
			chk(sda_rx === !sda_pull, "sda level");
			chk(pull_en === 1'b1 && fl_rx === flash_in, "pullup");
			chk((pins.flash_clk_oe_n | pins.flash_cs_oe_n | pins.flash_dout_oe_n) === 1'b0
				&& {pins.flash_clk, pins.flash_cs_n, pins.flash_dout} === exp_flash(mode, fdrive),
				"flash pins");
		end
		$display("test firmware states done");
		final_report();
	end
endmodule : tb_top

// File: verilog/isp_reset_and_pin_states.sv
// reset sources and pin-state control of the image processor
// assumes i_arst_n is the power-on reset cell output and all pins are sampled on i_clk
`timescale 1ns/1ns
module isp_reset_and_pin_states (
	input  wire logic                     i_clk,
	input  wire logic                     i_arst_n,
	input  wire logic                     i_hard_reset_n,
	input  wire logic                     i_standby,
	input  wire logic                     i_host_serial_data,
	input  wire logic                     i_flash_data_in,
	input  wire logic                     i_soft_reset_cmd,
	input  wire logic                     i_sda_pull_low,
	input  wire logic                     i_fw_booted,
	input  wire rst_pin_pkg::fw_mode_t    i_fw_mode,
	input  wire logic                     i_fw_sensor_release,
	input  wire rst_pin_pkg::flash_drive_t i_flash_drive,
	output rst_pin_pkg::pin_drive_t       o_pins,
	output rst_pin_pkg::dev_state_t       o_state,
	output logic                          o_core_reset_n,
	output logic                          o_host_link_ready,
	output logic                          o_auto_config,
	output logic                          o_flash_pullup_en,
	output logic                          o_host_serial_data_rx,
	output logic                          o_flash_data_rx
);
	import rst_pin_pkg::*;

	logic             hard_n_sync;
	logic             standby_sync;
	logic [CNT_W-1:0] por_cnt_reg;
	logic [CNT_W-1:0] soft_cnt_reg;
	logic [CNT_W-1:0] link_cnt_reg;
	logic             soft_fire;
	dev_state_t       state_reg;
	dev_state_t       state_next;
	pin_drive_t       pins_next;

	function automatic dev_state_t fw_to_state(input fw_mode_t m);
		unique case (m)
			FW_SOFT_STANDBY: fw_to_state = ST_SOFT_STANDBY;
			FW_STREAMING:    fw_to_state = ST_STREAMING;
			FW_IDLE:         fw_to_state = ST_IDLE;
			default:         fw_to_state = ST_IDLE;
		endcase
	endfunction : fw_to_state

	pin_sync #(.W(1), .RST_VAL(HARD_N_RST_VAL)) u_sync_hard (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_d      (i_hard_reset_n),
		.o_q      (hard_n_sync)
	);
	pin_sync #(.W(1), .RST_VAL(STANDBY_RST_VAL)) u_sync_stby (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_d      (i_standby),
		.o_q      (standby_sync)
	);
	pin_sync #(.W(1), .RST_VAL(SDA_RST_VAL)) u_sync_sda (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_d      (i_host_serial_data),
		.o_q      (o_host_serial_data_rx)
	);
	pin_sync #(.W(1), .RST_VAL(FLASH_RST_VAL)) u_sync_flash (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_d      (i_flash_data_in),
		.o_q      (o_flash_data_rx)
	);

	// stretch the power-on reset so the synchronisers settle first
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			por_cnt_reg <= POR_STRETCH_CYCLES;
		else if (por_cnt_reg != '0)
			por_cnt_reg <= por_cnt_reg - 1'b1;
	end

	assign soft_fire = i_soft_reset_cmd && (state_reg != ST_RESET);

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			soft_cnt_reg <= '0;
		else if (!hard_n_sync)
			soft_cnt_reg <= '0;
		else if (soft_fire)
			soft_cnt_reg <= SOFT_RESET_CYCLES;
		else if (soft_cnt_reg != '0)
			soft_cnt_reg <= soft_cnt_reg - 1'b1;
	end

	always_comb
	begin
		state_next = state_reg;
		if (por_cnt_reg != '0 || !hard_n_sync || soft_cnt_reg != '0 || soft_fire)
			state_next = ST_RESET;
		else
		begin
			unique case (state_reg)
				ST_RESET:
					state_next = ST_DEFAULT;
				ST_DEFAULT:
					if (standby_sync)
						state_next = ST_HARD_STANDBY;
					else if (i_fw_booted)
						state_next = fw_to_state(i_fw_mode);
				ST_HARD_STANDBY:
					if (!standby_sync)
						state_next = i_fw_booted ? fw_to_state(i_fw_mode) : ST_DEFAULT;
				ST_SOFT_STANDBY, ST_STREAMING, ST_IDLE:
					state_next = standby_sync ? ST_HARD_STANDBY : fw_to_state(i_fw_mode);
				default:
					state_next = ST_RESET;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			state_reg <= ST_RESET;
		else
			state_reg <= state_next;
	end

	assign o_state = state_reg;

	// pins follow state_next so a pin level and o_state change on the same edge
	always_comb
	begin
		pins_next = PINS_HIZ;
		if (hard_n_sync)
		begin
			pins_next.sensor_reset_oe_n = 1'b0;
			pins_next.sensor_reset_n    = i_fw_sensor_release &&
				(state_next != ST_RESET) && (state_next != ST_DEFAULT);
			if (state_next != ST_RESET)
			begin
				pins_next.flash_clk_oe_n  = 1'b0;
				pins_next.flash_cs_oe_n   = 1'b0;
				pins_next.flash_dout_oe_n = 1'b0;
				pins_next.host_serial_data_oe_n = !i_sda_pull_low;
				if (state_next == ST_STREAMING || state_next == ST_IDLE)
				begin
					pins_next.flash_clk  = i_flash_drive.clk;
					pins_next.flash_cs_n = i_flash_drive.cs_n;
					pins_next.flash_dout = i_flash_drive.dout;
				end
			end
		end
		pins_next.host_serial_data = 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_pins <= PINS_HIZ;
		else
			o_pins <= pins_next;
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_core_reset_n <= 1'b0;
		else
			o_core_reset_n <= (state_next != ST_RESET);
	end

	// advisory only: the device cannot stop a host that talks too early
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			link_cnt_reg      <= '0;
			o_host_link_ready <= 1'b0;
		end
		else if (!hard_n_sync || por_cnt_reg != '0)
		begin
			link_cnt_reg      <= '0;
			o_host_link_ready <= 1'b0;
		end
		else if (link_cnt_reg != FIRST_SERIAL_CYCLES)
		begin
			link_cnt_reg      <= link_cnt_reg + 1'b1;
			o_host_link_ready <= (link_cnt_reg == FIRST_SERIAL_CYCLES - 1'b1);
		end
	end

	// strap: the pull-up makes an empty flash socket read as auto-configure
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_auto_config <= AUTO_CFG_RST;
		else if (state_reg == ST_RESET && state_next == ST_DEFAULT)
			o_auto_config <= o_flash_data_rx;
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_flash_pullup_en <= PULLUP_RST;
		else
			o_flash_pullup_en <= 1'b1;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	chk_por_holds_reset: assert property (
		(por_cnt_reg != '0) |-> (state_reg == ST_RESET) && !o_core_reset_n)
		else $error("reset left before power-on stretch ended");
	chk_hard_pin_reset: assert property (
		!hard_n_sync |=> (state_reg == ST_RESET) && !o_core_reset_n)
		else $error("hard reset pin low but not in reset");
	chk_soft_reset_hold: assert property (
		(soft_fire && hard_n_sync) |=> (state_reg == ST_RESET) [*8])
		else $error("soft reset too short");
	chk_sda_never_high: assert property (
		!o_pins.host_serial_data_oe_n |-> !o_pins.host_serial_data)
		else $error("host serial data driven high");
	chk_pullup_always_on: assert property (
		o_flash_pullup_en)
		else $error("flash input pull-up disabled");
	chk_strap_capture: assert property (
		(state_reg == ST_RESET && state_next == ST_DEFAULT)
			|=> o_auto_config == $past(o_flash_data_rx))
		else $error("auto-config strap not captured");
	chk_link_ready_wait: assert property (
		$rose(o_host_link_ready) |-> $past(hard_n_sync, 100))
		else $error("link ready before 100 cycles");
	chk_outputs_hiz_pin: assert property (
		!hard_n_sync |=> o_pins.flash_clk_oe_n && o_pins.flash_cs_oe_n &&
			o_pins.flash_dout_oe_n && o_pins.sensor_reset_oe_n &&
			o_pins.host_serial_data_oe_n)
		else $error("output driven during hard reset");
	chk_sensor_reset_low: assert property (
		(state_reg == ST_RESET || state_reg == ST_DEFAULT) |-> !o_pins.sensor_reset_n)
		else $error("sensor reset released in reset or default");

	cov_soft_reset:   cover property (soft_fire ##1 (state_reg == ST_RESET));
	cov_hard_standby: cover property (state_reg == ST_HARD_STANDBY ##1 state_reg != ST_HARD_STANDBY);
	cov_streaming:    cover property (state_reg == ST_STREAMING && o_pins.sensor_reset_n);
	cov_link_ready:   cover property ($rose(o_host_link_ready));

endmodule : isp_reset_and_pin_states

// File: verilog/pin_sync.sv
// two-stage synchroniser for pins arriving from outside the clock domain
// assumes the reset value is a constant chosen by the instantiating module
`timescale 1ns/1ns
module pin_sync #(
	parameter int unsigned W         = 1,
	parameter logic [W-1:0] RST_VAL  = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_arst_n,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			meta_reg <= RST_VAL;
			o_q      <= RST_VAL;
		end
		else
		begin
			meta_reg <= i_d;
			o_q      <= meta_reg;
		end
	end
endmodule : pin_sync

// File: verilog/rst_pin_pkg.sv
// constants and types for the reset and pin-state controller
// assumes one reference clock at 20 MHz that also counts the reference-clock cycles
package rst_pin_pkg;

	localparam int unsigned CNT_W               = 8;
	localparam logic [CNT_W-1:0] POR_STRETCH_CYCLES  = 8'h10;
	localparam logic [CNT_W-1:0] SOFT_RESET_CYCLES   = 8'h08;
	localparam logic [CNT_W-1:0] FIRST_SERIAL_CYCLES = 8'h64;

	localparam logic HARD_N_RST_VAL  = 1'b0;
	localparam logic STANDBY_RST_VAL = 1'b0;
	localparam logic SDA_RST_VAL     = 1'b1;
	localparam logic FLASH_RST_VAL   = 1'b1;
	localparam logic AUTO_CFG_RST    = 1'b1;
	localparam logic PULLUP_RST      = 1'b1;

	typedef enum logic [2:0] {
		ST_RESET        = 3'h0,
		ST_DEFAULT      = 3'h1,
		ST_HARD_STANDBY = 3'h2,
		ST_SOFT_STANDBY = 3'h3,
		ST_STREAMING    = 3'h4,
		ST_IDLE         = 3'h5
	} dev_state_t;

	typedef enum logic [1:0] {
		FW_SOFT_STANDBY = 2'h0,
		FW_STREAMING    = 2'h1,
		FW_IDLE         = 2'h2
	} fw_mode_t;

	typedef struct packed {
		logic clk;
		logic cs_n;
		logic dout;
	} flash_drive_t;

	typedef struct packed {
		logic flash_clk;
		logic flash_clk_oe_n;
		logic flash_cs_n;
		logic flash_cs_oe_n;
		logic flash_dout;
		logic flash_dout_oe_n;
		logic sensor_reset_n;
		logic sensor_reset_oe_n;
		logic host_serial_data;
		logic host_serial_data_oe_n;
	} pin_drive_t;

	localparam pin_drive_t PINS_HIZ = '{
		flash_clk: 1'b0, flash_clk_oe_n: 1'b1, flash_cs_n: 1'b1, flash_cs_oe_n: 1'b1,
		flash_dout: 1'b0, flash_dout_oe_n: 1'b1, sensor_reset_n: 1'b0,
		sensor_reset_oe_n: 1'b1, host_serial_data: 1'b0, host_serial_data_oe_n: 1'b1};

endpackage : rst_pin_pkg
